// [sbb_pkg.sv]
// Package for the serial bus byte access block: offsets, fields, timing, types
package sbb_pkg;
    // Register offsets in configuration space
    localparam logic [7:0] OFF_BYTE_VALUE = 8'hb0;
    localparam logic [7:0] OFF_BYTE_OFFSET = 8'hb1;
    localparam logic [7:0] OFF_TARGET_SELECT = 8'hb2;
    localparam logic [7:0] OFF_CTRL_STATUS = 8'hb3;
    // Control/status field positions
    localparam int CS_SHORT_BIT = 7;
    localparam int CS_BUSY_BIT = 5;
    localparam int CS_TEST_BIT = 2;
    localparam int CS_FAULT_BIT = 1;
    // Reset value and the byte shifted out while reading
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    // Serial clock timing, one bit is four quarter phases
    localparam int CLK_HZ = 50_000_000;
    localparam int SCL_NORM_HZ = 100_000;
    localparam int SCL_TEST_HZ = 400_000;
    localparam logic [7:0] QTR_NORM_CYC = 8'(CLK_HZ / (4 * SCL_NORM_HZ));
    localparam logic [7:0] QTR_TEST_CYC = 8'(CLK_HZ / (4 * SCL_TEST_HZ));
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [1:0] Q_SAMPLE = 2'h2;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // Engine states
    typedef enum logic [1:0] {SBB_IDLE, SBB_START, SBB_BIT, SBB_STOP} sbb_fsm_e;
    // Byte phases of a frame
    typedef enum logic [2:0] {PH_ADDR_W, PH_OFFSET, PH_DATA, PH_ADDR_R, PH_READ} sbb_phase_e;
    // Configuration access from the host
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sbb_cfg_req_s;
    // Whole state of the engine and register file
    typedef struct packed {
        sbb_fsm_e fsm;
        sbb_phase_e phase;
        logic [1:0] q;
        logic [3:0] bitn;
        logic [7:0] div;
        logic [7:0] shreg;
        logic sda_low;
        logic scl_low;
        logic [7:0] byte_value;
        logic [7:0] byte_offset;
        logic [7:0] target_select;
        logic short_sel;
        logic test_fast;
        logic busy;
        logic fault;
        logic [7:0] rdata;
    } sbb_state_s;
endpackage

// [sbb_sync2.sv]
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module sbb_sync2 #(
    parameter int W = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Asynchronous level in, synchronised level out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    // Both stages held in one state word
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sbb_sync_s;

    sbb_sync_s st_ff; // Registered stages
    sbb_sync_s nxt_st; // Next value

    // First stage feeds only the second stage
    always_comb begin
        nxt_st = st_ff;
        nxt_st.stage1 = async_in;
        nxt_st.stage2 = st_ff.stage1;
    end

    // Lines idle high after reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.stage2;
endmodule // sbb_sync2

// [sbb_serial_byte.sv]
// Serial bus byte access engine with its configuration registers
`timescale 1ns/1ps
module sbb_serial_byte (
    // Clock and resets
    input wire logic core_clk,
    input wire logic rst,
    input wire logic soft_rst,
    // Configuration access
    input wire sbb_pkg::sbb_cfg_req_s cfg_req,
    output logic [7:0] cfg_rdata,
    // Status
    output logic request_in_progress,
    // Serial clock pin
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    // Serial data pin
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);
    import sbb_pkg::*;

    sbb_state_s s_ff; // Registered state
    sbb_state_s nxt_s; // Next state
    logic [1:0] pins_sync; // Synchronised scl, sda
    logic scl_s; // Sampled clock line
    logic sda_s; // Sampled data line
    logic tick; // Quarter phase enable
    logic adv; // Quarter phase advance after stretch check

    // Byte to shift out for a phase
    function automatic logic [7:0] byte_for(input sbb_phase_e ph, input sbb_state_s st);
        logic [7:0] b;
        b = IDLE_BYTE;
        unique case (ph)
            PH_ADDR_W: b = {st.target_select[7:1], 1'b0};
            PH_ADDR_R: b = {st.target_select[7:1], 1'b1};
            PH_OFFSET: b = st.byte_offset;
            PH_DATA: b = st.byte_value;
            PH_READ: b = IDLE_BYTE;
        endcase
        return b;
    endfunction

    // Pins pass two flip-flops first
    sbb_sync2 #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({scl_i, sda_i}),
        .sync_out(pins_sync)
    );
    assign scl_s = pins_sync[1];
    assign sda_s = pins_sync[0];

    // Divider and clock stretch hold
    assign tick = (s_ff.div == (s_ff.test_fast ? QTR_TEST_CYC : QTR_NORM_CYC) - 8'h01);
    assign adv = tick && (s_ff.scl_low || scl_s);

    // Next state: register access first, then the engine
    always_comb begin
        nxt_s = s_ff;
        nxt_s.div = tick ? 8'h00 : s_ff.div + 8'h01;
        // Register reads return a flopped byte
        if (cfg_req.rd) begin
            unique case (cfg_req.addr)
                OFF_BYTE_VALUE: nxt_s.rdata = s_ff.byte_value;
                OFF_BYTE_OFFSET: nxt_s.rdata = s_ff.byte_offset;
                OFF_TARGET_SELECT: nxt_s.rdata = s_ff.target_select;
                OFF_CTRL_STATUS: begin
                    nxt_s.rdata = REG_RESET;
                    nxt_s.rdata[CS_SHORT_BIT] = s_ff.short_sel;
                    nxt_s.rdata[CS_BUSY_BIT] = s_ff.busy;
                    nxt_s.rdata[CS_TEST_BIT] = s_ff.test_fast;
                    nxt_s.rdata[CS_FAULT_BIT] = s_ff.fault;
                end
                default: nxt_s.rdata = REG_RESET;
            endcase
        end
        // Register writes; transfer registers frozen while busy
        if (cfg_req.wr) begin
            unique case (cfg_req.addr)
                OFF_BYTE_VALUE: if (!s_ff.busy) nxt_s.byte_value = cfg_req.wdata;
                OFF_BYTE_OFFSET: if (!s_ff.busy) nxt_s.byte_offset = cfg_req.wdata;
                OFF_TARGET_SELECT: begin
                    if (!s_ff.busy && !soft_rst) begin
                        // Launch the transfer
                        nxt_s.target_select = cfg_req.wdata;
                        nxt_s.busy = 1'b1;
                        nxt_s.fsm = SBB_START;
                        nxt_s.q = 2'h0;
                        nxt_s.div = 8'h00;
                        nxt_s.phase = (s_ff.short_sel && cfg_req.wdata[0]) ? PH_ADDR_R : PH_ADDR_W;
                    end
                end
                OFF_CTRL_STATUS: begin
                    nxt_s.short_sel = cfg_req.wdata[CS_SHORT_BIT];
                    nxt_s.test_fast = cfg_req.wdata[CS_TEST_BIT];
                    if (cfg_req.wdata[CS_FAULT_BIT]) nxt_s.fault = 1'b0;
                end
                default: ;
            endcase
        end
        // Bit engine, one step per quarter phase
        if (adv) begin
            unique case (s_ff.fsm)
                SBB_IDLE: ;
                SBB_START: begin
                    // Start or repeated start
                    unique case (s_ff.q)
                        2'h0: nxt_s.sda_low = 1'b0;
                        2'h1: nxt_s.scl_low = 1'b0;
                        2'h2: nxt_s.sda_low = 1'b1;
                        2'h3: begin
                            nxt_s.scl_low = 1'b1;
                            nxt_s.fsm = SBB_BIT;
                            nxt_s.bitn = 4'h0;
                            nxt_s.shreg = byte_for(s_ff.phase, s_ff);
                        end
                    endcase
                    nxt_s.q = s_ff.q + 2'h1;
                end
                SBB_BIT: begin
                    unique case (s_ff.q)
                        2'h0: nxt_s.sda_low = (s_ff.phase != PH_READ && s_ff.bitn != ACK_SLOT) && !s_ff.shreg[7];
                        2'h1: nxt_s.scl_low = 1'b0;
                        2'h2: begin
                            if (s_ff.bitn != ACK_SLOT) nxt_s.shreg = {s_ff.shreg[6:0], sda_s};
                        end
                        2'h3: begin
                            nxt_s.scl_low = 1'b1;
                            nxt_s.bitn = s_ff.bitn + 4'h1;
                        end
                    endcase
                    nxt_s.q = s_ff.q + 2'h1;
                    // Acknowledge slot closes the byte
                    if (s_ff.q == Q_SAMPLE && s_ff.bitn == ACK_SLOT && s_ff.phase != PH_READ && sda_s) begin
                        nxt_s.fault = 1'b1;
                        nxt_s.phase = PH_READ;
                    end
                    if (s_ff.q == Q_LAST && s_ff.bitn == ACK_SLOT) begin
                        nxt_s.bitn = 4'h0;
                        unique case (s_ff.phase)
                            PH_ADDR_W: nxt_s.phase = s_ff.short_sel ? PH_DATA : PH_OFFSET;
                            PH_OFFSET: begin
                                nxt_s.phase = s_ff.target_select[0] ? PH_ADDR_R : PH_DATA;
                                if (s_ff.target_select[0]) nxt_s.fsm = SBB_START;
                            end
                            PH_ADDR_R: nxt_s.phase = PH_READ;
                            PH_DATA: nxt_s.fsm = SBB_STOP;
                            PH_READ: begin
                                nxt_s.fsm = SBB_STOP;
                                if (s_ff.target_select[0] && !s_ff.fault) nxt_s.byte_value = s_ff.shreg;
                            end
                        endcase
                        if (nxt_s.fsm == SBB_BIT) nxt_s.shreg = byte_for(nxt_s.phase, s_ff);
                    end
                end
                SBB_STOP: begin
                    unique case (s_ff.q)
                        2'h0: nxt_s.sda_low = 1'b1;
                        2'h1: nxt_s.scl_low = 1'b0;
                        2'h2: nxt_s.sda_low = 1'b0;
                        2'h3: begin
                            nxt_s.fsm = SBB_IDLE;
                            nxt_s.busy = 1'b0;
                        end
                    endcase
                    nxt_s.q = s_ff.q + 2'h1;
                end
            endcase
        end
        // Secondary reset stops the engine but keeps the registers
        if (soft_rst) begin
            nxt_s.fsm = SBB_IDLE;
            nxt_s.q = 2'h0;
            nxt_s.bitn = 4'h0;
            nxt_s.sda_low = 1'b0;
            nxt_s.scl_low = 1'b0;
            nxt_s.busy = 1'b0;
        end
    end

    // State register, cleared by the global reset only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Open-drain pins pull low only
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = s_ff.scl_low;
    assign sda_oe = s_ff.sda_low;
    assign cfg_rdata = s_ff.rdata;
    assign request_in_progress = s_ff.busy;

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence launch_seq;
        cfg_req.wr && cfg_req.addr == OFF_TARGET_SELECT && !s_ff.busy && !soft_rst;
    endsequence
    sequence start_cond_seq;
        s_ff.fsm == SBB_START && s_ff.q == 2'h2 && adv;
    endsequence

    chk_launch_busy: assert property (launch_seq |=> s_ff.busy && s_ff.fsm == SBB_START)
        else $error("target write did not launch");
    chk_start_edge: assert property (start_cond_seq |=> s_ff.sda_low && !s_ff.scl_low)
        else $error("start not data low with clock high");
    chk_busy_ends: assert property ($fell(s_ff.busy) |-> $past(s_ff.fsm) == SBB_STOP || $past(soft_rst))
        else $error("busy cleared outside stop");
    chk_fault_clear: assert property (cfg_req.wr && cfg_req.addr == OFF_CTRL_STATUS && cfg_req.wdata[CS_FAULT_BIT]
        && !adv |=> !s_ff.fault)
        else $error("fault not cleared by write one");
    chk_short_skip: assert property (s_ff.phase == PH_OFFSET && s_ff.busy |-> !s_ff.short_sel)
        else $error("offset phase in short protocol");
    chk_read_dir: assert property (s_ff.phase == PH_ADDR_R && s_ff.busy |-> s_ff.target_select[0])
        else $error("read address phase on write request");
    chk_soft_keeps: assert property (soft_rst && !cfg_req.wr |=> $stable(s_ff.byte_offset)
        && $stable(s_ff.target_select) && $stable(s_ff.byte_value))
        else $error("soft reset changed registers");
    chk_offset_frozen: assert property (s_ff.busy |=> $stable(s_ff.byte_offset))
        else $error("offset changed during transfer");
    // A launch at normal rate gives the first quarter step 125 cycles later, 500 cycles per bit
    chk_tick_rate: assert property (launch_seq && !s_ff.test_fast |-> ##124 !tick ##1 tick)
        else $error("quarter phase not at normal rate");
endmodule // sbb_serial_byte

// [sbb_target_model.sv]
// Behavioural serial bus target: byte store, log of host bytes, optional clock stretch
`timescale 1ns/1ps
module sbb_target_model #(
    parameter logic [6:0] DEV_ADDR = 7'h50
) (
    // Line levels as seen on the wires
    input wire logic scl,
    input wire logic sda,
    // Hold the clock low after each byte
    input wire logic stretch,
    // High pulls the line low
    output logic pull_scl,
    output logic pull_sda
);
    logic [7:0] mem [256]; // Byte store
    logic [7:0] log_q [$]; // Bytes sent by the host
    logic [7:0] sh; // Receive shifter
    logic [7:0] ptr; // Current byte address
    logic active; // Inside a frame that is ours
    logic first; // Next byte is an address byte
    logic sel; // Address matched
    logic rd_mode; // Host reads from us
    logic rd_done; // Our data byte has gone out
    int bitc; // Bit count in the byte
    int nwr; // Bytes written after the address
    // Known contents so reads have a predictable answer
    initial begin
        pull_scl = 0;
        pull_sda = 0;
        active = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    end
    // Start or repeated start opens a frame
    always @(negedge sda) if (scl === 1'b1) begin
        active = 1;
        first = 1;
        bitc = 0;
        rd_mode = 0;
        rd_done = 0;
    end
    // Stop closes it
    always @(posedge sda) if (scl === 1'b1) active = 0;
    // Bits are taken while the clock is high
    always @(posedge scl) if (active && bitc < 8) begin
        sh = {sh[6:0], sda};
        bitc++;
    end
    // Data and acknowledge change only while the clock is low
    always @(negedge scl) if (active) begin
        if (bitc == 8) begin
            bitc = 9;
            if (rd_mode && !first) begin
                // Our byte is out, host answers in the next slot
                pull_sda = 0;
                rd_done = 1;
            end else begin
                log_q.push_back(sh);
                if (first) begin
                    sel = (sh[7:1] == DEV_ADDR);
                    rd_mode = sh[0];
                    first = 0;
                    nwr = 0;
                    active = sel;
                end else begin
                    if (nwr == 0) ptr = sh;
                    else mem[ptr] = sh;
                    nwr++;
                end
                pull_sda = sel;
            end
            // Slow answer: keep the clock low for a while
            if (stretch) begin
                pull_scl = 1;
                #3000;
                pull_scl = 0;
            end
        end else if (bitc == 9) begin
            bitc = 0;
            pull_sda = rd_mode && !rd_done && !mem[ptr][7];
        end else if (rd_mode && !rd_done) pull_sda = !mem[ptr][7-bitc];
    end
endmodule // sbb_target_model

// [tb_top.sv]
// Self-checking bench for the serial bus byte access block
`timescale 1ns/1ps
module tb_top;
    import sbb_pkg::*;
    localparam logic [6:0] DEV = 7'h50; // Target address of the model
    logic core_clk, rst, soft_rst, scl_oe, sda_oe, t_scl, t_sda, stretch, busy, scl_o, sda_o;
    sbb_cfg_req_s cfg_req; // Host access
    logic [7:0] cfg_rdata, rv, bad, o1, d, o2;
    int seed = 69080;
    int num_errors = 0;
    int check_count = 0;
    time t0;
    wire scl_w = !(scl_oe | t_scl); // Pulled-up lines
    wire sda_w = !(sda_oe | t_sda);
    sbb_serial_byte u_dut (.core_clk(core_clk), .rst(rst), .soft_rst(soft_rst), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .request_in_progress(busy), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
    sbb_target_model #(.DEV_ADDR(DEV)) u_tgt (.scl(scl_w), .sda(sda_w), .stretch(stretch),
        .pull_scl(t_scl), .pull_sda(t_sda));
    // 50 MHz clock
    initial begin
        core_clk = 0;
        forever #10 core_clk = ~core_clk;
    end
    // Compare and count
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    // One-cycle register write
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge core_clk) cfg_req = '{1'b1, 1'b0, a, v};
        @(negedge core_clk) cfg_req.wr = 1'b0;
    endtask
    // One-cycle register read, data taken once settled
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge core_clk) cfg_req = '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk) cfg_req.rd = 1'b0;
        @(negedge core_clk) v = cfg_rdata;
    endtask
    // Poll the busy flag until it clears, bounded
    task wait_idle;
        rd(OFF_CTRL_STATUS, rv);
        repeat (20000) if (rv[CS_BUSY_BIT] !== 1'b0) rd(OFF_CTRL_STATUS, rv);
        // A transfer that never ends counts as a mismatch here
        chk("busy bit idle", 8'h00, 8'(rv[CS_BUSY_BIT]));
        chk("busy pin idle", 8'h00, 8'(busy));
    endtask
    // Compare the bytes the target saw from the host
    task frame(input int n, input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        logic [7:0] e [3];
        e = '{a, b, c};
        chk("frame length", 8'(n), 8'(u_tgt.log_q.size()));
        for (int i = 0; i < n; i++) chk("frame byte", e[i], u_tgt.log_q[i]);
        u_tgt.log_q.delete();
    endtask
    // Byte expected from the target store
    function automatic logic [7:0] exp_byte(input logic [7:0] o);
        return (o == o1) ? d : (o ^ 8'h5a);
    endfunction
    task test_done;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog
    initial begin
        #1_500_000;
        num_errors++;
        test_done;
    end
    // Main sequence
    initial begin
        rst = 1;
        soft_rst = 0;
        stretch = 0;
        cfg_req = '0;
        repeat (8) @(negedge core_clk);
        rst = 0;
        // Reset values, unmapped place included
        for (int a = 0; a < 5; a++) begin
            rd(8'(OFF_BYTE_VALUE + a), rv);
            chk("reset value", 8'h00, rv);
        end
        $display("test reset done");
        // Unanswered address: fault, clear by writing one, soft reset keeps registers
        bad = {DEV ^ (7'($random(seed)) | 7'h01), 1'b0};
        wr(OFF_CTRL_STATUS, 8'h04);
        wr(OFF_TARGET_SELECT, bad);
        wait_idle;
        chk("fault flag", 8'h06, rv);
        // The unanswered address byte is the only byte on the wire
        frame(1, bad, 8'h00, 8'h00);
        wr(OFF_CTRL_STATUS, 8'h06);
        rd(OFF_CTRL_STATUS, rv);
        chk("fault cleared", 8'h04, rv);
        @(negedge core_clk) soft_rst = 1;
        @(negedge core_clk) soft_rst = 0;
        rd(OFF_TARGET_SELECT, rv);
        chk("target kept", bad, rv);
        $display("test fault done");
        // Byte write at normal rate
        d = 8'($random(seed));
        o1 = 8'($random(seed));
        wr(OFF_CTRL_STATUS, 8'h00);
        wr(OFF_BYTE_VALUE, d);
        wr(OFF_BYTE_OFFSET, o1);
        wr(OFF_TARGET_SELECT, {DEV, 1'b0});
        rd(OFF_CTRL_STATUS, rv);
        chk("busy set", 8'h20, rv);
        chk("busy pin set", 8'h01, 8'(busy));
        // Open-drain pins may only ever pull low
        chk("pin drive level", 8'h00, {6'h00, scl_o, sda_o});
        wr(OFF_BYTE_OFFSET, ~o1);
        @(posedge scl_w) t0 = $time;
        @(posedge scl_w) chk("scl period", 8'h01, 8'(($time - t0) inside {[9600:10400]}));
        wait_idle;
        chk("status after write", 8'h00, rv);
        rd(OFF_BYTE_OFFSET, rv);
        chk("offset kept", o1, rv);
        frame(3, {DEV, 1'b0}, o1, d);
        chk("target store", d, u_tgt.mem[o1]);
        $display("test write done");
        // Byte read, fast rate, slow target
        wr(OFF_CTRL_STATUS, 8'h04);
        stretch = 1;
        wr(OFF_BYTE_OFFSET, o1);
        wr(OFF_TARGET_SELECT, {DEV, 1'b1});
        wait_idle;
        stretch = 0;
        rd(OFF_BYTE_VALUE, rv);
        chk("read data", d, rv);
        frame(3, {DEV, 1'b0}, o1, {DEV, 1'b1});
        $display("test read done");
        // Short protocol: send byte, then receive byte
        o2 = 8'($random(seed));
        wr(OFF_CTRL_STATUS, 8'h84);
        wr(OFF_BYTE_VALUE, o2);
        wr(OFF_TARGET_SELECT, {DEV, 1'b0});
        wait_idle;
        frame(2, {DEV, 1'b0}, o2, 8'h00);
        wr(OFF_TARGET_SELECT, {DEV, 1'b1});
        wait_idle;
        rd(OFF_BYTE_VALUE, rv);
        chk("short read", exp_byte(o2), rv);
        frame(1, {DEV, 1'b1}, 8'h00, 8'h00);
        $display("test short done");
        test_done;
    end
endmodule // tb_top
